/* File: core/anlp_pkg.sv */
// package: register map, field layout and carriers for the partner base page bank
package anlp_pkg;
  // management device and register offsets
  localparam logic [4:0] ANLP_MMD_DEV = 5'h07;
  localparam logic [15:0] ANLP_OFS_LOW = 16'h0205;
  localparam logic [15:0] ANLP_OFS_MID = 16'h0206;
  localparam logic [15:0] ANLP_OFS_HIGH = 16'h0207;
  localparam logic [15:0] ANLP_RESET_VAL = 16'h0000;
  // low word field positions
  localparam int ANLP_LO_NP = 15;
  localparam int ANLP_LO_ACK = 14;
  localparam int ANLP_LO_RF = 13;
  localparam int ANLP_LO_FORCE = 12;
  localparam int ANLP_LO_PAUSE_HI = 11;
  localparam int ANLP_LO_PAUSE_LO = 10;
  localparam int ANLP_LO_SEL_HI = 4;
  localparam int ANLP_LO_SEL_LO = 0;
  localparam logic [4:0] ANLP_SELECTOR_ETH = 5'h01;
  // middle word field positions
  localparam int ANLP_MI_B10L = 14;
  localparam int ANLP_MI_B1000 = 7;
  localparam int ANLP_MI_B10S_FD = 6;
  localparam int ANLP_MI_B100 = 5;
  localparam int ANLP_MI_ROLE = 4;
  // high word field positions
  localparam int ANLP_HI_EEE = 14;
  localparam int ANLP_HI_LVL_ABL = 13;
  localparam int ANLP_HI_LVL_REQ = 12;
  localparam int ANLP_HI_B10S_HD = 11;
  // storage slots of the snapshot memory
  localparam logic [0:0] ANLP_SLOT_MID = 1'b0;
  localparam logic [0:0] ANLP_SLOT_HIGH = 1'b1;

  // decoded fields of a received base page
  typedef struct packed {
    logic partner_more_pages_flag;
    logic partner_ack_flag;
    logic partner_fault_flag;
    logic partner_role_forced;
    logic [1:0] partner_flow_ctrl_ability;
    logic [4:0] partner_selector_field;
    logic partner_long_reach_ability;
    logic partner_gigabit_ability;
    logic partner_short_reach_fd_ability;
    logic partner_fast_ability;
    logic partner_role_value;
    logic partner_eee_ability;
    logic partner_hi_level_ability;
    logic partner_hi_level_request;
    logic partner_short_reach_hd_ability;
  } anlp_page_s;

  // register bus request
  typedef struct packed {
    logic [4:0] dev;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } anlp_bus_s;
endpackage

/* File: core/anlp_regs.sv */
// partner base page ability registers with snapshot on low word read
`timescale 1ns/1ns
`default_nettype none
// How it works
// - reading the low word snapshots the middle and high words
// - middle word reads return the snapshot, not the live page
// - low bit 15 shows partner wants to send a next page
// - low bit 14 shows partner acknowledged our codeword
// - low bit 13 shows partner remote fault
// - low bit 12 shows partner role forced (1) or preferred (0)
// - low bits 11:10 show partner pause abilities
// - low bits 4:0 carry the received selector, standard value 00001
// - middle bit 14 shows partner long reach ability
// - middle bits 7,6,5 show gigabit, short reach full duplex, fast
// - middle bit 4 shows partner role, 1 master, 0 slave
// - registers at device 7, offsets 0205/0206/0207, reset zero, writes ignored
// - high word also snapshotted on low read and read back from snapshot
module anlp_regs
  import anlp_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // received page from the arbitration logic
  input wire logic PAGE_VALID,
  input wire anlp_page_s PAGE_IN,
  // register port
  input wire logic [4:0] REG_DEV,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // live snapshot status
  output logic SNAP_VALID
);
  anlp_bus_s bus;
  anlp_page_s live;
  logic [15:0] next_low_word;
  logic [15:0] live_mid;
  logic [15:0] live_high;
  logic [15:0] mem_rdata;
  logic [15:0] low_rdata;
  logic [1:0] rd_kind;
  logic next_snap_valid;
  wire logic hit_dev;
  wire logic rd_low;
  wire logic rd_mid;
  wire logic rd_high;
  wire logic rd_mem;
  wire logic [0:0] mem_slot;

  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_LOW = 2'h1;
  localparam logic [1:0] KIND_MEM = 2'h2;

  // pack the live page into the middle word image, reserved bits zero
  function automatic logic [15:0] mid_image(input anlp_page_s p);
    logic [15:0] w;
    w = ANLP_RESET_VAL;
    w[ANLP_MI_B10L] = p.partner_long_reach_ability;
    w[ANLP_MI_B1000] = p.partner_gigabit_ability;
    w[ANLP_MI_B10S_FD] = p.partner_short_reach_fd_ability;
    w[ANLP_MI_B100] = p.partner_fast_ability;
    w[ANLP_MI_ROLE] = p.partner_role_value;
    return w;
  endfunction

  // pack the live page into the high word image
  function automatic logic [15:0] high_image(input anlp_page_s p);
    logic [15:0] w;
    w = ANLP_RESET_VAL;
    w[ANLP_HI_EEE] = p.partner_eee_ability;
    w[ANLP_HI_LVL_ABL] = p.partner_hi_level_ability;
    w[ANLP_HI_LVL_REQ] = p.partner_hi_level_request;
    w[ANLP_HI_B10S_HD] = p.partner_short_reach_hd_ability;
    return w;
  endfunction

  // pack the low word image
  function automatic logic [15:0] low_image(input anlp_page_s p);
    logic [15:0] w;
    w = ANLP_RESET_VAL;
    w[ANLP_LO_NP] = p.partner_more_pages_flag;
    w[ANLP_LO_ACK] = p.partner_ack_flag;
    w[ANLP_LO_RF] = p.partner_fault_flag;
    w[ANLP_LO_FORCE] = p.partner_role_forced;
    w[ANLP_LO_PAUSE_HI:ANLP_LO_PAUSE_LO] = p.partner_flow_ctrl_ability;
    w[ANLP_LO_SEL_HI:ANLP_LO_SEL_LO] = p.partner_selector_field;
    return w;
  endfunction

  // bus bundle; write data is carried but never stored
  assign bus = '{dev: REG_DEV, addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

  // address decode; writes to any offset are ignored
  assign hit_dev = (bus.dev == ANLP_MMD_DEV);
  assign rd_low = bus.rd && hit_dev && (bus.addr == ANLP_OFS_LOW);
  assign rd_mid = bus.rd && hit_dev && (bus.addr == ANLP_OFS_MID);
  assign rd_high = bus.rd && hit_dev && (bus.addr == ANLP_OFS_HIGH);
  assign rd_mem = rd_mid || rd_high;
  assign mem_slot = rd_high ? ANLP_SLOT_HIGH : ANLP_SLOT_MID;

  // live images follow the page register
  assign live_mid = mid_image(live);
  assign live_high = high_image(live);
  assign next_low_word = low_image(live);

  // live page register, loaded whenever a new base page is accepted
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      live <= '0;
    end else if (PAGE_VALID) begin
      live <= PAGE_IN;
    end
  end

  // snapshot store; capture fires with the low read itself
  anlp_snap_mem u_snap (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .cap(rd_low),
    .cap_mid(live_mid),
    .cap_high(live_high),
    .rd(rd_mem),
    .rd_slot(mem_slot),
    .rd_data(mem_rdata)
  );

  // low word read data captured at the strobe; snapshot flag set on first low read
  assign next_snap_valid = SNAP_VALID || rd_low;
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      low_rdata <= ANLP_RESET_VAL;
      rd_kind <= KIND_NONE;
      SNAP_VALID <= 1'b0;
    end else begin
      low_rdata <= rd_low ? next_low_word : ANLP_RESET_VAL;
      rd_kind <= rd_low ? KIND_LOW : (rd_mem ? KIND_MEM : KIND_NONE);
      SNAP_VALID <= next_snap_valid;
    end
  end

  // read mux: unmapped addresses and idle cycles read zero
  always_comb begin
    case (rd_kind)
      KIND_LOW: REG_RDATA = low_rdata;
      KIND_MEM: REG_RDATA = mem_rdata;
      default: REG_RDATA = ANLP_RESET_VAL;
    endcase
  end

  // a middle read right after a low read returns the word seen at that low read
  a_mid_from_snap: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_mid |=> REG_RDATA == $past(live_mid, 2))
    else $error("middle read does not return snapshot");

  a_high_from_snap: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_high |=> REG_RDATA == $past(live_high, 2))
    else $error("high read does not return snapshot");

  a_snap_held: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 (!rd_low && PAGE_VALID) ##1 rd_mid |=> REG_RDATA == $past(live_mid, 3))
    else $error("snapshot changed without a low read");

  a_low_live: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low |=> REG_RDATA == $past(next_low_word))
    else $error("low read does not show live page");

  a_low_reserved: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low |=> REG_RDATA[9:5] == 5'h00)
    else $error("low reserved bits not zero");

  a_mid_reserved: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_mid |=> (REG_RDATA[15] == 1'b0) && (REG_RDATA[13:8] == 6'h00)
      && (REG_RDATA[3:0] == 4'h0))
    else $error("middle reserved bits not zero");

  a_unmapped_zero: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (!rd_low && !rd_mem) |=> REG_RDATA == ANLP_RESET_VAL)
    else $error("idle or unmapped read not zero");

  a_page_update: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    PAGE_VALID ##1 rd_low |=> REG_RDATA[ANLP_LO_SEL_HI:ANLP_LO_SEL_LO]
      == $past(PAGE_IN.partner_selector_field, 2))
    else $error("accepted page not reflected in low word");

  a_snap_flag: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low |=> SNAP_VALID)
    else $error("snapshot flag not set after low read");

  // low word fields, one by one, so a swapped bit names itself
  a_low_next_page: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low |=> REG_RDATA[ANLP_LO_NP] == $past(live.partner_more_pages_flag))
    else $error("low next page bit wrong");

  // acknowledge bit
  a_low_ack_bit: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low |=> REG_RDATA[ANLP_LO_ACK] == $past(live.partner_ack_flag))
    else $error("low acknowledge bit wrong");

  // remote fault bit
  a_low_fault_bit: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low |=> REG_RDATA[ANLP_LO_RF] == $past(live.partner_fault_flag))
    else $error("low fault bit wrong");

  // forced or preferred role
  a_low_role_forced: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low |=> REG_RDATA[ANLP_LO_FORCE] == $past(live.partner_role_forced))
    else $error("low role forced bit wrong");

  // pause pair keeps its order
  a_low_pause_bits: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low |=> REG_RDATA[ANLP_LO_PAUSE_HI:ANLP_LO_PAUSE_LO]
      == $past(live.partner_flow_ctrl_ability))
    else $error("low pause bits wrong");

  // selector as received
  a_low_selector: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low |=> REG_RDATA[ANLP_LO_SEL_HI:ANLP_LO_SEL_LO]
      == $past(live.partner_selector_field))
    else $error("low selector wrong");

  // middle word fields come from the page seen at the low read
  a_mid_long_reach: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_mid |=> REG_RDATA[ANLP_MI_B10L]
      == $past(live.partner_long_reach_ability, 2))
    else $error("middle long reach bit wrong");

  // gigabit bit
  a_mid_gigabit: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_mid |=> REG_RDATA[ANLP_MI_B1000]
      == $past(live.partner_gigabit_ability, 2))
    else $error("middle gigabit bit wrong");

  // short reach full duplex bit
  a_mid_short_fd: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_mid |=> REG_RDATA[ANLP_MI_B10S_FD]
      == $past(live.partner_short_reach_fd_ability, 2))
    else $error("middle short reach bit wrong");

  // fast bit
  a_mid_fast: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_mid |=> REG_RDATA[ANLP_MI_B100]
      == $past(live.partner_fast_ability, 2))
    else $error("middle fast bit wrong");

  // role value bit
  a_mid_role: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_mid |=> REG_RDATA[ANLP_MI_ROLE]
      == $past(live.partner_role_value, 2))
    else $error("middle role bit wrong");

  // high word reserved bits
  a_high_reserved: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_high |=> (REG_RDATA[15] == 1'b0) && (REG_RDATA[10:0] == 11'h000))
    else $error("high reserved bits not zero");

  // high word fields from the snapshot
  a_high_eee: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_high |=> REG_RDATA[ANLP_HI_EEE]
      == $past(live.partner_eee_ability, 2))
    else $error("high eee bit wrong");

  // level ability bit
  a_high_lvl_abl: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_high |=> REG_RDATA[ANLP_HI_LVL_ABL]
      == $past(live.partner_hi_level_ability, 2))
    else $error("high level ability bit wrong");

  // level request bit
  a_high_lvl_req: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_high |=> REG_RDATA[ANLP_HI_LVL_REQ]
      == $past(live.partner_hi_level_request, 2))
    else $error("high level request bit wrong");

  // short reach half duplex bit
  a_high_short_hd: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_high |=> REG_RDATA[ANLP_HI_B10S_HD]
      == $past(live.partner_short_reach_hd_ability, 2))
    else $error("high short reach bit wrong");

  // before any low read the snapshot is still the reset value
  a_mid_before_snap: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !SNAP_VALID && rd_mid |=> REG_RDATA == ANLP_RESET_VAL)
    else $error("middle read before snapshot not zero");

  // same for the high word
  a_high_before_snap: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !SNAP_VALID && rd_high |=> REG_RDATA == ANLP_RESET_VAL)
    else $error("high read before snapshot not zero");

  // the flag only clears on reset
  a_snap_sticky: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    SNAP_VALID |=> SNAP_VALID)
    else $error("snapshot flag dropped");

  // and only a low read sets it
  a_snap_only_low: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !SNAP_VALID && !rd_low |=> !SNAP_VALID)
    else $error("snapshot flag set without low read");

  // a write alone never produces read data
  a_write_ignored: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    REG_WR && !REG_RD |=> REG_RDATA == ANLP_RESET_VAL)
    else $error("write produced read data");

  // reads of another device return zero
  a_other_dev: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    REG_RD && !hit_dev |=> REG_RDATA == ANLP_RESET_VAL)
    else $error("other device read not zero");

  // read data stand for one cycle only
  a_read_one_cycle: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 !REG_RD |=> REG_RDATA == ANLP_RESET_VAL)
    else $error("read data held past one cycle");

  // an accepted page loads the live register
  a_live_load: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    PAGE_VALID |=> live == $past(PAGE_IN))
    else $error("accepted page not loaded");

  // without a page the live register holds
  a_live_hold: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !PAGE_VALID |=> $stable(live))
    else $error("live page changed without a page");

  // a middle read between does not disturb the high snapshot
  a_high_after_mid: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_mid ##1 rd_high |=> REG_RDATA == $past(live_high, 3))
    else $error("high snapshot lost after middle read");

  // repeated middle reads return the same snapshot
  a_mid_twice: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_mid ##1 rd_mid |=> REG_RDATA == $past(live_mid, 3))
    else $error("second middle read differs");

  // repeated high reads return the same snapshot
  a_high_twice: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 rd_high ##1 rd_high |=> REG_RDATA == $past(live_high, 3))
    else $error("second high read differs");

  // a page landing after the low read stays out of the high snapshot
  a_snap_held_high: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_low ##1 (!rd_low && PAGE_VALID) ##1 rd_high |=> REG_RDATA == $past(live_high, 3))
    else $error("high snapshot changed without a low read");

  // a page accepted just before a low read shows in full
  a_low_after_page: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    PAGE_VALID ##1 rd_low |=> REG_RDATA == low_image($past(PAGE_IN, 2)))
    else $error("fresh page not in low word");

  // and lands in the middle snapshot
  a_mid_after_page: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    PAGE_VALID ##1 rd_low ##1 rd_mid |=> REG_RDATA == mid_image($past(PAGE_IN, 3)))
    else $error("fresh page not in middle snapshot");

  // and in the high snapshot
  a_high_after_page: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    PAGE_VALID ##1 rd_low ##1 rd_high |=> REG_RDATA == high_image($past(PAGE_IN, 3)))
    else $error("fresh page not in high snapshot");
endmodule
`default_nettype wire

/* File: core/anlp_snap_mem.sv */
// two-word snapshot store with registered read data
`timescale 1ns/1ns
`default_nettype none
module anlp_snap_mem
  import anlp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // write port: both words captured together
  input wire logic cap,
  input wire logic [15:0] cap_mid,
  input wire logic [15:0] cap_high,
  // read port
  input wire logic rd,
  input wire logic [0:0] rd_slot,
  output logic [15:0] rd_data
);
  logic [15:0] mem [2];

  // both slots load in one cycle so the pair is always coherent
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem[ANLP_SLOT_MID] <= ANLP_RESET_VAL;
      mem[ANLP_SLOT_HIGH] <= ANLP_RESET_VAL;
    end else if (cap) begin
      mem[ANLP_SLOT_MID] <= cap_mid;
      mem[ANLP_SLOT_HIGH] <= cap_high;
    end
  end

  // read data held in a register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= ANLP_RESET_VAL;
    end else if (rd) begin
      rd_data <= mem[rd_slot];
    end
  end
endmodule
`default_nettype wire

/* File: testbench/anlp_regs_bench.sv */
// self-checking bench for the partner base page register bank
`timescale 1ns/1ns
`default_nettype none
module anlp_regs_bench
  import anlp_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b1;
  logic page_valid = 1'b0;
  anlp_page_s page_in = '0;
  logic [4:0] reg_dev = 5'h00;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic snap_valid;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  // two pages whose ability bits are opposite; both carry the normal selector
  localparam anlp_page_s PAGE_A = 20'hA_8355;
  localparam anlp_page_s PAGE_B = 20'h5_42AA;

  anlp_regs uut (.CLK_SYS(clk_sys), .RESETN(resetn), .PAGE_VALID(page_valid),
    .PAGE_IN(page_in), .REG_DEV(reg_dev), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SNAP_VALID(snap_valid));

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  // expected words, built from bit positions independently of the design
  function automatic logic [15:0] lo_w(anlp_page_s p);
    return {p.partner_more_pages_flag, p.partner_ack_flag, p.partner_fault_flag,
      p.partner_role_forced, p.partner_flow_ctrl_ability, 5'h00, p.partner_selector_field};
  endfunction
  function automatic logic [15:0] mid_w(anlp_page_s p);
    return {1'b0, p.partner_long_reach_ability, 6'h00, p.partner_gigabit_ability,
      p.partner_short_reach_fd_ability, p.partner_fast_ability, p.partner_role_value, 4'h0};
  endfunction
  function automatic logic [15:0] hi_w(anlp_page_s p);
    return {1'b0, p.partner_eee_ability, p.partner_hi_level_ability,
      p.partner_hi_level_request, p.partner_short_reach_hd_ability, 11'h000};
  endfunction

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard: the whole run needs under a hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic load(anlp_page_s p);
    @(posedge clk_sys);
    page_valid <= 1'b1;
    page_in <= p;
    @(posedge clk_sys);
    page_valid <= 1'b0;
  endtask

  // single read; data are looked at in the one cycle after the strobe
  task automatic rd(logic [4:0] dev, logic [15:0] addr, string what, logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_dev <= dev;
    reg_addr <= addr;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask

  task automatic wr(logic [15:0] addr, logic [15:0] data);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_dev <= ANLP_MMD_DEV;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic t_reset();
    rd(ANLP_MMD_DEV, ANLP_OFS_LOW, "low", ANLP_RESET_VAL);
    chk("snap", {15'h0000, snap_valid}, 16'h0001);
    rd(ANLP_MMD_DEV, ANLP_OFS_MID, "mid", ANLP_RESET_VAL);
    rd(ANLP_MMD_DEV, ANLP_OFS_HIGH, "high", ANLP_RESET_VAL);
    $display("test reset done");
  endtask

  task automatic t_fields();
    load(PAGE_A);
    rd(ANLP_MMD_DEV, ANLP_OFS_LOW, "low a", lo_w(PAGE_A));
    chk("snap", {15'h0000, snap_valid}, 16'h0001);
    rd(ANLP_MMD_DEV, ANLP_OFS_MID, "mid a", mid_w(PAGE_A));
    rd(ANLP_MMD_DEV, ANLP_OFS_HIGH, "high a", hi_w(PAGE_A));
    $display("test fields done");
  endtask

  // new live page must stay hidden until the next low read
  task automatic t_snapshot();
    load(PAGE_B);
    rd(ANLP_MMD_DEV, ANLP_OFS_MID, "mid held", mid_w(PAGE_A));
    rd(ANLP_MMD_DEV, ANLP_OFS_HIGH, "high held", hi_w(PAGE_A));
    rd(ANLP_MMD_DEV, ANLP_OFS_LOW, "low b", lo_w(PAGE_B));
    load(PAGE_A);
    rd(ANLP_MMD_DEV, ANLP_OFS_MID, "mid b", mid_w(PAGE_B));
    rd(ANLP_MMD_DEV, ANLP_OFS_HIGH, "high b", hi_w(PAGE_B));
    $display("test snapshot done");
  endtask

  // low, mid, high with no gap: the low read snapshots at its own edge
  task automatic t_b2b();
    logic [15:0] addrs [3];
    logic [15:0] exps [3];
    addrs = '{ANLP_OFS_LOW, ANLP_OFS_MID, ANLP_OFS_HIGH};
    exps = '{lo_w(PAGE_A), mid_w(PAGE_A), hi_w(PAGE_A)};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      reg_rd <= (i < 3);
      reg_dev <= ANLP_MMD_DEV;
      reg_addr <= (i < 3) ? addrs[i] : 16'h0000;
      #1;
      if (i > 0) chk("b2b", reg_rdata, exps[i-1]);
    end
    $display("test back to back done");
  endtask

  // writes change nothing; unmapped places read zero
  task automatic t_writes();
    wr(ANLP_OFS_LOW, 16'hFFFF);
    wr(ANLP_OFS_MID, 16'hFFFF);
    rd(ANLP_MMD_DEV, ANLP_OFS_MID, "mid wr", mid_w(PAGE_A));
    rd(ANLP_MMD_DEV, ANLP_OFS_LOW, "low wr", lo_w(PAGE_A));
    rd(ANLP_MMD_DEV, 16'h0208, "unmapped", 16'h0000);
    rd(5'h06, ANLP_OFS_LOW, "other dev", 16'h0000);
    $display("test writes done");
  endtask

  // pages packed tight around reads: after a low read hidden, before one shown
  task automatic t_tight();
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_dev <= ANLP_MMD_DEV;
    reg_addr <= ANLP_OFS_LOW;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    page_valid <= 1'b1;
    page_in <= PAGE_B;
    #1;
    chk("tight low", reg_rdata, lo_w(PAGE_A));
    @(posedge clk_sys);
    page_valid <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= ANLP_OFS_MID;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    page_valid <= 1'b1;
    page_in <= PAGE_A;
    #1;
    chk("tight mid", reg_rdata, mid_w(PAGE_A));
    @(posedge clk_sys);
    page_valid <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= ANLP_OFS_LOW;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("tight page", reg_rdata, lo_w(PAGE_A));
    $display("test tight done");
  endtask

  task automatic t_rereset();
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    chk("snap rst", {15'h0000, snap_valid}, 16'h0000);
    rd(ANLP_MMD_DEV, ANLP_OFS_MID, "mid rst", ANLP_RESET_VAL);
    rd(ANLP_MMD_DEV, ANLP_OFS_HIGH, "high rst", ANLP_RESET_VAL);
    rd(ANLP_MMD_DEV, ANLP_OFS_LOW, "low rst", ANLP_RESET_VAL);
    $display("test second reset done");
  endtask

  // main sequence
  initial begin
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_fields();
    t_snapshot();
    t_b2b();
    t_writes();
    t_tight();
    t_rereset();
    close_out();
  end
endmodule
`default_nettype wire
